/* File: rtl/acie_checker.sv */
// Addressed ASCII command receiver, checker, setup store and responder.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Extended address write stores two characters when enabled
// - Extended address read returns stored characters
// - Any error aborts command, error reply sent
// - Error reply: question mark, address, space, text
// - Eight error texts, distinct first characters
// - Illegal address codes give address error
// - Address above seven-F rejected
// - Appended hex pair checked as checksum
// - Unknown or lower-case mnemonic gives command error
// - Commands during calibration answer not ready
// - Power-up, restart command, watchdog start calibration
// - Parity error only when parity enabled
// - Wrong structure or length gives syntax error
// - Bad digit in hex field gives value error
// - Writes need preceding write enable
// - Valid enabled setup stores four bytes
// - Setup operand exactly eight hex characters
// - Bit 7 most significant, first character upper
// - Non-hex operand character other than lower-case a..f aborts with syntax error
// - Setup readback returns stored bytes when no error is reported
// - Write enable cleared by next successful command
// - Linefeed before and after reply when enabled
module acie_checker #(
    parameter int CAL_CYCLES = acie_pkg::CAL_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_par_err,
    input wire logic i_wdog_trip,
    input wire logic i_tx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic [31:0] o_config,
    output logic [15:0] o_ext_addr,
    output logic o_nvm_write,
    output logic o_ready
);
    import acie_pkg::*;

    acie_state_t state_q;
    logic [7:0] buf_q [BUF_DEPTH];
    logic [4:0] len_q;
    logic ovf_q;
    logic par_q;
    logic [31:0] cfg_q;
    logic [15:0] xa_q;
    logic we_q;
    logic nvm_wr_q;
    logic restart_q;
    logic cal_ready;
    logic ok_q;
    acie_err_t err_q;
    logic hash_q;
    logic rsp_lf_q;
    logic restart_pend_q;
    logic [4:0] echo_n_q;
    logic [4:0] pay_n_q;
    logic [4:0] ck_n_q;
    logic [31:0] rdval_q;
    logic [4:0] oi_q;
    logic [7:0] osum_q;

    logic is_prompt;
    logic buf_wr;
    logic addr_match;
    acie_cmd_t cmd;
    logic [4:0] mlen;
    logic [4:0] oplen;
    logic [4:0] base;
    logic has_ck;
    logic ck_ok;
    logic bad_syn;
    logic bad_val;
    logic [7:0] sum;
    logic [31:0] opval;
    logic ok_d;
    acie_err_t err_d;
    logic [4:0] e_end;
    logic [4:0] p_end;
    logic [4:0] k_end;
    logic [4:0] j;
    logic [7:0] cur_char;
    logic frm_ready;
    logic take;
    logic last;

    assign is_prompt = i_rx_data == CH_DOLLAR || i_rx_data == CH_HASH;
    assign buf_wr = i_rx_valid && (state_q == ST_IDLE || state_q == ST_RECV) &&
        (is_prompt || (state_q == ST_RECV && i_rx_data != CH_CR));

    // Input is ignored while a reply is built or sent; the line is half duplex.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            len_q <= 5'h00;
            ovf_q <= 1'b0;
            par_q <= 1'b0;
        end else if (buf_wr) begin
            if (is_prompt) begin
                len_q <= 5'h01;
                ovf_q <= 1'b0;
                par_q <= i_rx_par_err && cfg_q[CFG_PAR_EN_BIT];
            end else begin
                if (len_q < 5'(BUF_DEPTH)) begin
                    len_q <= len_q + 5'h01;
                end else begin
                    ovf_q <= 1'b1;
                end
                par_q <= par_q || (i_rx_par_err && cfg_q[CFG_PAR_EN_BIT]);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (buf_wr && (is_prompt || len_q < 5'(BUF_DEPTH))) begin
            buf_q[is_prompt ? 4'h0 : len_q[3:0]] <= i_rx_data;
        end
    end

    assign addr_match = len_q >= HDR_LEN && buf_q[1] == cfg_q[31:24];

    always_comb begin
        cmd = CMD_NONE;
        mlen = 5'h02;
        oplen = 5'h00;
        if (len_q >= 5'h05 && {buf_q[2], buf_q[3], buf_q[4]} == MN_XA_WRITE) begin
            cmd = CMD_XA_WRITE;
            mlen = 5'h03;
            oplen = OP_LEN_XA;
        end else if (len_q >= 5'h05 && {buf_q[2], buf_q[3], buf_q[4]} == MN_XA_READ) begin
            cmd = CMD_XA_READ;
            mlen = 5'h03;
        end else if (len_q >= MIN_CMD_LEN) begin
            case ({buf_q[2], buf_q[3]})
                MN_WR_ENABLE: cmd = CMD_WE;
                MN_CFG_LOAD: begin
                    cmd = CMD_CFG_LOAD;
                    oplen = OP_LEN_CFG;
                end
                MN_CFG_READ: cmd = CMD_CFG_READ;
                MN_RESTART: cmd = CMD_RESTART;
                default: cmd = CMD_NONE;
            endcase
        end
        base = HDR_LEN + mlen + oplen;
        has_ck = len_q == base + CK_LEN && is_hex(buf_q[base[3:0]]) &&
            is_hex(buf_q[4'(base + 5'h01)]);
        sum = 8'h00;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (5'(i) < base) begin
                sum = sum + buf_q[i];
            end
        end
        ck_ok = {hex_val(buf_q[base[3:0]]), hex_val(buf_q[4'(base + 5'h01)])} == sum;
        bad_syn = ovf_q || (len_q != base && !has_ck);
        bad_val = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (5'(k) < oplen && !is_hex(buf_q[4'(HDR_LEN + mlen + 5'(k))])) begin
                // Lower-case a..f is a digit outside the range; anything else breaks form.
                if (buf_q[4'(HDR_LEN + mlen + 5'(k))] inside {[8'h61:8'h66]}) begin
                    bad_val = 1'b1;
                end else begin
                    bad_syn = 1'b1;
                end
            end
        end
        opval = 32'h0;
        for (int k = 0; k < 8; k++) begin
            opval[4 * (7 - k) +: 4] = hex_val(buf_q[4'(HDR_LEN + mlen + 5'(k))]);
        end
        ok_d = 1'b0;
        if (!cal_ready) begin
            err_d = ERR_NRDY;
        end else if (par_q) begin
            err_d = ERR_PAR;
        end else if (len_q < MIN_CMD_LEN) begin
            err_d = ERR_SYNTAX;
        end else if (cmd == CMD_NONE) begin
            err_d = ERR_CMD;
        end else if (has_ck && !ck_ok) begin
            err_d = ERR_CKSUM;
        end else if (bad_syn) begin
            err_d = ERR_SYNTAX;
        end else if (bad_val) begin
            err_d = ERR_VALUE;
        end else if ((cmd == CMD_CFG_LOAD || cmd == CMD_XA_WRITE || cmd == CMD_RESTART) &&
            !we_q) begin
            err_d = ERR_WPROT;
        end else if (cmd == CMD_CFG_LOAD && !addr_legal(opval[31:24])) begin
            err_d = ERR_ADDR;
        end else begin
            err_d = ERR_ADDR;
            ok_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (i_rx_valid && is_prompt) state_q <= ST_RECV;
                ST_RECV: if (i_rx_valid && i_rx_data == CH_CR) state_q <= ST_EVAL;
                // Commands for other addresses are dropped without a reply.
                ST_EVAL: state_q <= addr_match ? ST_SEND : ST_IDLE;
                ST_SEND: if (take && last) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Effects are committed only on a clean command, so an error changes nothing.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cfg_q <= CFG_RESET;
            xa_q <= EXT_ADDR_RESET;
            we_q <= 1'b0;
            nvm_wr_q <= 1'b0;
        end else begin
            nvm_wr_q <= 1'b0;
            if (state_q == ST_EVAL && addr_match && ok_d) begin
                if (cmd == CMD_CFG_LOAD) begin
                    cfg_q <= opval;
                    nvm_wr_q <= 1'b1;
                end
                if (cmd == CMD_XA_WRITE) begin
                    xa_q <= opval[31:16];
                    nvm_wr_q <= 1'b1;
                end
                we_q <= cmd == CMD_WE;
            end else if (state_q == ST_EVAL && addr_match && err_d == ERR_WPROT) begin
                we_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ok_q <= 1'b0;
            err_q <= ERR_ADDR;
            hash_q <= 1'b0;
            rsp_lf_q <= 1'b0;
            restart_pend_q <= 1'b0;
            echo_n_q <= 5'h00;
            pay_n_q <= 5'h00;
            ck_n_q <= 5'h00;
            rdval_q <= 32'h0;
        end else if (state_q == ST_EVAL) begin
            ok_q <= ok_d;
            err_q <= err_d;
            hash_q <= buf_q[0] == CH_HASH;
            // Old linefeed setting frames the reply even when a setup changes it.
            rsp_lf_q <= cfg_q[CFG_LF_BIT];
            restart_pend_q <= ok_d && cmd == CMD_RESTART;
            echo_n_q <= !ok_d ? 5'h02 : (buf_q[0] == CH_HASH ? base - 5'h01 : 5'h00);
            pay_n_q <= !ok_d ? ERR_LEN[err_d] : (cmd == CMD_CFG_READ ? OP_LEN_CFG :
                (cmd == CMD_XA_READ ? OP_LEN_XA : 5'h00));
            ck_n_q <= (ok_d && buf_q[0] == CH_HASH) ? CK_LEN : 5'h00;
            rdval_q <= cmd == CMD_CFG_READ ? cfg_q : {xa_q, 16'h0};
        end
    end

    assign e_end = 5'h01 + echo_n_q;
    assign p_end = e_end + pay_n_q;
    assign k_end = p_end + ck_n_q;
    assign j = oi_q - e_end;
    assign last = oi_q == k_end;

    always_comb begin
        if (oi_q == 5'h00) begin
            cur_char = ok_q ? CH_STAR : CH_QMARK;
        end else if (oi_q < e_end) begin
            cur_char = ok_q ? buf_q[oi_q[3:0]] : (oi_q == 5'h01 ? cfg_q[31:24] : CH_SPACE);
        end else if (oi_q < p_end) begin
            cur_char = ok_q ? hex_char(rdval_q[{~j[2:0], 2'b00} +: 4]) :
                ERR_TEXT[err_q][{~j[3:0], 3'b000} +: 8];
        end else if (oi_q < k_end) begin
            cur_char = hex_char(oi_q == p_end ? osum_q[7:4] : osum_q[3:0]);
        end else begin
            cur_char = CH_CR;
        end
    end

    assign take = state_q == ST_SEND && frm_ready;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            oi_q <= 5'h00;
            osum_q <= 8'h00;
            restart_q <= 1'b0;
        end else begin
            restart_q <= take && last && restart_pend_q;
            if (state_q == ST_EVAL) begin
                oi_q <= 5'h00;
                osum_q <= 8'h00;
            end else if (take) begin
                oi_q <= oi_q + 5'h01;
                if (oi_q < p_end) begin
                    osum_q <= osum_q + cur_char;
                end
            end
        end
    end

    acie_tx_frame u_frame (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(state_q == ST_SEND),
        .i_data(cur_char),
        .i_first(oi_q == 5'h00),
        .i_last(last),
        .i_lf_en(rsp_lf_q),
        .o_ready(frm_ready),
        .o_tx_valid(o_tx_valid),
        .o_tx_data(o_tx_data),
        .i_tx_ready(i_tx_ready)
    );

    acie_cal_timer #(.CYCLES(CAL_CYCLES)) u_cal (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(restart_q || i_wdog_trip),
        .o_ready(cal_ready)
    );

    assign o_config = cfg_q;
    assign o_ext_addr = xa_q;
    assign o_nvm_write = nvm_wr_q;
    assign o_ready = cal_ready;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    property p_wr_needs_we;
        o_nvm_write |-> $past(we_q) && !we_q;
    endproperty
    a_wr_needs_we: assert property (p_wr_needs_we) else $error("write without enable");

    property p_nrdy;
        (state_q == ST_EVAL && addr_match && !cal_ready) |=> (!ok_q && err_q == ERR_NRDY);
    endproperty
    a_nrdy: assert property (p_nrdy) else $error("not-ready error missing");

    property p_err_no_effect;
        (state_q == ST_EVAL && !ok_d) |=> ($stable(cfg_q) && $stable(xa_q) && !o_nvm_write);
    endproperty
    a_err_no_effect: assert property (p_err_no_effect) else $error("error changed state");

    property p_err_format;
        (state_q == ST_SEND && !ok_q && oi_q == 5'h02) |-> cur_char == CH_SPACE;
    endproperty
    a_err_format: assert property (p_err_format) else $error("error format wrong");

    property p_par_off;
        (buf_wr && !cfg_q[CFG_PAR_EN_BIT]) |=> !par_q;
    endproperty
    a_par_off: assert property (p_par_off) else $error("parity flagged while off");

    property p_addr_legal;
        o_nvm_write |-> addr_legal(o_config[31:24]);
    endproperty
    a_addr_legal: assert property (p_addr_legal) else $error("illegal address stored");

    property p_restart;
        (take && last && restart_pend_q) |=> ##1 !o_ready;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not recalibrate");

    property p_ck_err;
        (state_q == ST_EVAL && addr_match && cal_ready && !par_q && cmd != CMD_NONE &&
            len_q >= MIN_CMD_LEN && has_ck && !ck_ok) |=> err_q == ERR_CKSUM;
    endproperty
    a_ck_err: assert property (p_ck_err) else $error("bad checksum not reported");

    c_cfg_write: cover property (o_nvm_write && cmd == CMD_CFG_LOAD);
    c_wprot: cover property (state_q == ST_EVAL && addr_match && err_d == ERR_WPROT);
    c_hash_ok: cover property (state_q == ST_SEND && ok_q && hash_q && last && take);
endmodule : acie_checker
`default_nettype wire

/* File: rtl/acie_pkg.sv */
// Shared constants, types and helper functions of the ASCII command checker.
package acie_pkg;

    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_QMARK = 8'h3f;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_LBRACE = 8'h7b;
    localparam logic [7:0] CH_RBRACE = 8'h7d;
    localparam logic [7:0] CH_ADDR_MAX = 8'h7f;

    // Command mnemonics as ASCII pairs and triples.
    localparam logic [15:0] MN_WR_ENABLE = 16'h5745;
    localparam logic [15:0] MN_CFG_LOAD = 16'h5355;
    localparam logic [15:0] MN_CFG_READ = 16'h5253;
    localparam logic [15:0] MN_RESTART = 16'h5252;
    localparam logic [23:0] MN_XA_WRITE = 24'h574541;
    localparam logic [23:0] MN_XA_READ = 24'h524541;

    localparam int BUF_DEPTH = 16;
    localparam logic [4:0] HDR_LEN = 5'h02;
    localparam logic [4:0] CK_LEN = 5'h02;
    localparam logic [4:0] OP_LEN_CFG = 5'h08;
    localparam logic [4:0] OP_LEN_XA = 5'h04;
    localparam logic [4:0] MIN_CMD_LEN = 5'h04;

    localparam logic [31:0] CFG_RESET = 32'h31070080;
    localparam logic [15:0] EXT_ADDR_RESET = 16'h3030;
    localparam int CFG_LF_BIT = 23;
    localparam int CFG_PAR_EN_BIT = 21;

    localparam int CLK_MHZ = 200;
    localparam int CAL_TIME_MS = 2500;
    localparam int CAL_CYCLES = CAL_TIME_MS * CLK_MHZ * 1000;

    typedef enum logic [2:0] {
        ERR_ADDR = 3'b000,
        ERR_CKSUM = 3'b001,
        ERR_CMD = 3'b010,
        ERR_NRDY = 3'b011,
        ERR_PAR = 3'b100,
        ERR_SYNTAX = 3'b101,
        ERR_VALUE = 3'b110,
        ERR_WPROT = 3'b111
    } acie_err_t;

    typedef enum logic [2:0] {
        CMD_WE = 3'b000,
        CMD_CFG_LOAD = 3'b001,
        CMD_CFG_READ = 3'b010,
        CMD_RESTART = 3'b011,
        CMD_XA_WRITE = 3'b100,
        CMD_XA_READ = 3'b101,
        CMD_NONE = 3'b110
    } acie_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_EVAL = 2'b10,
        ST_SEND = 2'b11
    } acie_state_t;

    // Texts are padded to 16 characters; only the first ERR_LEN are sent.
    localparam logic [127:0] ERR_TEXT [8] = '{
        "ADDRESS ERROR   ", "BAD CHECKSUM    ", "COMMAND ERROR   ", "NOT READY       ",
        "PARITY ERROR    ", "SYNTAX ERROR    ", "VALUE ERROR     ", "WRITE PROTECTED "};
    localparam logic [4:0] ERR_LEN [8] = '{5'h0d, 5'h0c, 5'h0d, 5'h09, 5'h0c, 5'h0c, 5'h0b,
        5'h0f};

    function automatic logic is_hex(input logic [7:0] c);
        return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction : is_hex

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        return (c >= 8'h41) ? 4'(c - 8'h37) : c[3:0];
    endfunction : hex_val

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n > 4'h9) ? 8'(8'h37 + {4'h0, n}) : {4'h3, n};
    endfunction : hex_char

    function automatic logic addr_legal(input logic [7:0] a);
        return a <= CH_ADDR_MAX && a != CH_NUL && a != CH_CR && a != CH_DOLLAR &&
            a != CH_HASH && a != CH_LBRACE && a != CH_RBRACE;
    endfunction : addr_legal

endpackage : acie_pkg

/* File: rtl/acie_cal_timer.sv */
// Self-calibration timer that holds the block not ready after each restart.
`timescale 1ns/1ps
`default_nettype none
module acie_cal_timer #(
    parameter int CYCLES = acie_pkg::CAL_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    output logic o_ready
);
    import acie_pkg::*;

    logic [31:0] cnt_q;
    logic ready_q;

    // Power-up reset and any later restart both rerun the full period.
    always_ff @(posedge i_clk) begin
        if (i_reset || i_start) begin
            cnt_q <= 32'h0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            cnt_q <= cnt_q + 32'h1;
            ready_q <= (cnt_q == 32'(CYCLES - 1));
        end
    end

    assign o_ready = ready_q;

    property p_start_busy;
        @(posedge i_clk) disable iff (i_reset) i_start |=> !ready_q;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("ready after restart");
endmodule : acie_cal_timer
`default_nettype wire

/* File: rtl/acie_tx_frame.sv */
// Response byte framer that wraps each response in linefeeds when enabled.
`timescale 1ns/1ps
`default_nettype none
module acie_tx_frame (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_first,
    input wire logic i_last,
    input wire logic i_lf_en,
    output logic o_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready
);
    import acie_pkg::*;

    logic valid_q;
    logic [7:0] data_q;
    logic [7:0] hold_q;
    logic pend_q;
    logic hold_last_q;
    logic post_q;
    logic adv;

    assign adv = !valid_q || i_tx_ready;
    assign o_ready = adv && !pend_q && !post_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            valid_q <= 1'b0;
            data_q <= 8'h00;
            hold_q <= 8'h00;
            pend_q <= 1'b0;
            hold_last_q <= 1'b0;
            post_q <= 1'b0;
        end else if (adv) begin
            if (pend_q) begin
                valid_q <= 1'b1;
                data_q <= hold_q;
                pend_q <= 1'b0;
                post_q <= hold_last_q;
            end else if (post_q) begin
                valid_q <= 1'b1;
                data_q <= CH_LF;
                post_q <= 1'b0;
            end else if (i_valid) begin
                valid_q <= 1'b1;
                if (i_first && i_lf_en) begin
                    data_q <= CH_LF;
                    hold_q <= i_data;
                    hold_last_q <= i_last;
                    pend_q <= 1'b1;
                end else begin
                    data_q <= i_data;
                    post_q <= i_last && i_lf_en;
                end
            end else begin
                valid_q <= 1'b0;
            end
        end
    end

    assign o_tx_valid = valid_q;
    assign o_tx_data = data_q;

    property p_lead_lf;
        @(posedge i_clk) disable iff (i_reset)
            (o_ready && i_valid && i_first && i_lf_en) |=> (o_tx_valid && o_tx_data == CH_LF);
    endproperty
    a_lead_lf: assert property (p_lead_lf) else $error("leading linefeed missing");
endmodule : acie_tx_frame
`default_nettype wire

/* File: sim/acie_host_model.sv */
// Host terminal model that sends command characters and collects the reply.
`timescale 1ns/1ps
`default_nettype none
module acie_host_model (
    input wire logic i_clk,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_par_err,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready
);
    string reply = "";
    logic slow = 1'b0;
    logic [1:0] phase = 2'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_rx_par_err = 1'b0;
        o_tx_ready = 1'b1;
    end
    // A slow host takes one character in four, so the reply must hold while stalled.
    always @(negedge i_clk) begin
        phase <= phase + 2'h1;
        o_tx_ready <= !slow || phase == 2'h3;
    end
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready) begin
            reply = {reply, string'(i_tx_data)};
        end
    end
    task automatic send(input string s, input logic par);
        int i;
        reply = "";
        for (i = 0; i <= s.len(); i++) begin
            @(negedge i_clk);
            o_rx_valid = 1'b1;
            o_rx_data = (i == s.len()) ? 8'h0d : s[i];
            o_rx_par_err = par;
        end
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        // An idle line must not keep showing the last character.
        o_rx_data = ~o_rx_data;
        o_rx_par_err = 1'b0;
    endtask : send
endmodule : acie_host_model
`default_nettype wire

/* File: sim/acie_checker_bench.sv */
// Self-checking testbench of the ASCII command checker.
`timescale 1ns/1ps
`default_nettype none
module acie_checker_bench;
    import acie_pkg::*;
    logic i_clk, i_reset, i_wdog_trip, rx_valid, rx_par_err, tx_ready, tx_valid, nvm_write, ready;
    logic [7:0] rx_data, tx_data;
    logic [31:0] cfg;
    logic [15:0] ext_addr;
    int errors = 0;
    int checked = 0;
    int writes = 0;
    always @(posedge i_clk) begin
        if (nvm_write === 1'b1) begin
            writes++;
        end
    end
    logic lf = 1'b0;
    logic [7:0] bad [7] = '{8'h00, 8'h0d, 8'h24, 8'h23, 8'h7b, 8'h7d, 8'h80};
    acie_host_model host_u (.i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .o_rx_par_err(rx_par_err), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready));
    acie_checker #(.CAL_CYCLES(20)) dut_u (.i_clk(i_clk), .i_reset(i_reset),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_par_err(rx_par_err),
        .i_wdog_trip(i_wdog_trip), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .o_config(cfg), .o_ext_addr(ext_addr), .o_nvm_write(nvm_write),
        .o_ready(ready));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check_val
    // Extra characters after the expected reply are caught by the trailing wait.
    task automatic cmd(input string s, input string exp, input logic par = 1'b0);
        string e;
        int n;
        e = lf ? {"\012", exp, "\015\012"} : {exp, "\015"};
        host_u.send(s, par);
        for (n = 0; n < 400 && host_u.reply.len() < e.len(); n++) @(posedge i_clk);
        repeat (8) @(posedge i_clk);
        checked++;
        if (host_u.reply != e) begin
            errors++;
            $display("MISMATCH reply to %s expected %s seen %s", s, exp, host_u.reply);
        end
    endtask : cmd
    task automatic wait_ready();
        int n;
        for (n = 0; n < 100 && ready !== 1'b1; n++) @(posedge i_clk);
        check_val("ready", 32'h1, {31'h0, ready});
    endtask : wait_ready
    task automatic t_calibrate();
        cmd("$1RS", "?1 NOT READY");
        wait_ready();
        $display("done calibrate");
    endtask : t_calibrate
    task automatic t_readback();
        cmd("$1RS", "*31070080");
        cmd("$1RSFA", "*31070080");
        cmd("$1RS00", "?1 BAD CHECKSUM");
        cmd("#1RS", "*1RS3107008093");
        cmd("$1rs", "?1 COMMAND ERROR");
        cmd("#1rs", "?1 COMMAND ERROR");
        cmd("$1RS", "*31070080", 1'b1);
        $display("done readback");
    endtask : t_readback
    task automatic t_setup();
        cmd("$1SU31870080", "?1 WRITE PROTECTED");
        check_val("config", 32'h31070080, cfg);
        cmd("$1WE", "*");
        cmd("$1SU3187X080", "?1 SYNTAX ERROR");
        cmd("$1SU318700a0", "?1 VALUE ERROR");
        cmd("$1SU318700800", "?1 SYNTAX ERROR");
        check_val("config", 32'h31070080, cfg);
        cmd("$1SU31870080", "*");
        check_val("config", 32'h31870080, cfg);
        lf = 1'b1;
        host_u.slow = 1'b1;
        cmd("$1RS", "*31870080");
        host_u.slow = 1'b0;
        cmd("$1SU31070080", "?1 WRITE PROTECTED");
        $display("done setup");
    endtask : t_setup
    task automatic t_address();
        int i;
        string s;
        cmd("$1WE", "*");
        for (i = 0; i < 7; i++) begin
            s = $sformatf("$1SU%h870080", bad[i]);
            cmd(s.toupper(), "?1 ADDRESS ERROR");
        end
        check_val("config", 32'h31870080, cfg);
        cmd("$1SU31270080", "*");
        lf = 1'b0;
        cmd("$1RS", "?1 PARITY ERROR", 1'b1);
        cmd("$1WE", "*");
        cmd("$1SU31070080", "*");
        $display("done address");
    endtask : t_address
    task automatic t_ext_addr();
        cmd("$1WE", "*");
        cmd("$1WEA3132", "*");
        check_val("ext_addr", 32'h3132, {16'h0, ext_addr});
        cmd("$1REA", "*3132");
        cmd("$1WEA3033", "?1 WRITE PROTECTED");
        check_val("ext_addr", 32'h3132, {16'h0, ext_addr});
        check_val("nvm_writes", 32'h4, writes);
        $display("done ext_addr");
    endtask : t_ext_addr
    task automatic t_restart();
        cmd("$1WE", "*");
        cmd("$1RR", "*");
        cmd("$1RS", "?1 NOT READY");
        wait_ready();
        @(negedge i_clk);
        i_wdog_trip = 1'b1;
        @(negedge i_clk);
        i_wdog_trip = 1'b0;
        cmd("$1RS", "?1 NOT READY");
        wait_ready();
        cmd("$1RS", "*31070080");
        $display("done restart");
    endtask : t_restart
    initial begin
        i_reset = 1'b1;
        i_wdog_trip = 1'b0;
        repeat (4) @(negedge i_clk);
        i_reset = 1'b0;
        t_calibrate();
        t_readback();
        t_setup();
        t_address();
        t_ext_addr();
        t_restart();
        complete_run();
    end
    // The tests need fewer than two thousand cycles; this allows ample slack.
    initial begin
        repeat (40000) @(posedge i_clk);
        errors++;
        complete_run();
    end
endmodule : acie_checker_bench
`default_nettype wire
